// *** inc/afe_cfg.svh ***
// register offsets, field positions, reset values for the front-end decoder
`ifndef AFE_CFG_SVH
`define AFE_CFG_SVH
`define AFE_OFF_STAGE_EN   12'h000
`define AFE_OFF_GAIN_OFS2  12'h004
`define AFE_OFF_GAIN3      12'h008
`define AFE_OFF_OFS3       12'h00C
`define AFE_OFF_INSEL      12'h010
`define AFE_OFF_STATUS     12'h014
`define AFE_RST_STAGE_EN   4'h1
`define AFE_MODE_BIT       4
`define AFE_SWAP_BIT       3
`define AFE_INSEL_LSB      1
`define AFE_REFSEL_BIT     0
`define AFE_OFS2_MAX       3'h5
`endif

// *** inc/afe_pkg.sv ***
// types shared by the front-end decoder files
package afe_pkg;
    typedef logic [7:0] afe_chan_t;   // one-hot analog input select
    typedef logic [3:0] afe_ref_t;    // reference pin pair select, two pins closed at once
endpackage : afe_pkg

// *** rtl/afe_mux_dec.sv ***
// combinational input and reference multiplexer decode
`timescale 1ns/1ps
`default_nettype none
module afe_mux_dec
    import afe_pkg::*;
(
    input  wire logic [4:0] input_select,     // mode, swap, channel
    input  wire logic       reference_select, // reference pair select
    output afe_pkg::afe_chan_t pos_sel,        // positive side one-hot
    output afe_pkg::afe_chan_t neg_sel,        // negative side one-hot
    output afe_pkg::afe_ref_t  ref_sel         // {3,2,1,0} pins
);
    wire logic       mode   = input_select[4];
    wire logic       swap   = input_select[3];
    wire logic [2:0] chan   = input_select[2:0];
    wire logic [2:0] dp_idx = {input_select[1:0], 1'b1};
    wire logic [2:0] dn_idx = {input_select[1:0], 1'b0};
    wire logic [2:0] p_idx  = mode ? chan : dp_idx;
    wire logic [2:0] n_idx  = mode ? 3'h0 : dn_idx;
    wire afe_chan_t  p_oh   = afe_chan_t'(8'h01 << p_idx);
    wire afe_chan_t  n_oh   = afe_chan_t'(8'h01 << n_idx);
    assign pos_sel = swap ? n_oh : p_oh;
    assign neg_sel = swap ? p_oh : n_oh;
    assign ref_sel = reference_select ? 4'hC : 4'h3;
endmodule : afe_mux_dec
`default_nettype wire

// *** rtl/afe_frontend.sv ***
// apb register file and registered switch controls for the analog front end
//
// Summary of operation
// - mode 0 connects odd input 2n+1 against even 2n, n from bits 1:0.
// - mode 1 connects the chosen input against input 0.
// - the swap bit exchanges positive and negative connections.
// - the input selection word lives in bits 5:1 of its register.
// - bit 0 picks reference pins 1/0 or 3/2.
// - enable bits drive the modulator and amplifier stages one to three.
// - three amplifier stages, offsets only on stages two and three.
// - stage one gain code selects gain 1 or 10.
// - stage two gain codes select gains 1, 2, 5 and 10.
// - stage two offset is sign-magnitude, magnitude 0 to 5 in 0.2 steps.
// - stage three gain is the seven-bit code over twelve.
// - stage three offset is sign-magnitude twelfths; minus zero is zero.
// - a disabled amplifier stage is bypassed, not blocked.
// - all controls are read/write and reset enables only the modulator.
`timescale 1ns/1ps
`default_nettype none
`include "afe_cfg.svh"
module afe_frontend
(
    input  wire logic        pclk,           // system clock
    input  wire logic        presetn,        // async reset, active low
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb enable
    input  wire logic        pwrite,         // apb direction
    input  wire logic [11:0] paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic      [31:0] prdata,         // apb read data
    output logic             pready,         // apb ready
    output logic             pslverr,        // apb error
    output afe_pkg::afe_chan_t pos_sel,      // positive input switches
    output afe_pkg::afe_chan_t neg_sel,      // negative input switches
    output afe_pkg::afe_ref_t  ref_sel,      // reference pin switches
    output logic             mod_en,         // modulator enable
    output logic       [3:1] stage_en,       // amplifier stage active
    output logic       [3:1] stage_bypass,   // amplifier stage bypassed
    output logic             stage1_gain,    // stage one gain code
    output logic       [1:0] stage2_gain,    // stage two gain code
    output logic             stage2_ofs_neg, // stage two offset sign
    output logic       [2:0] stage2_ofs_mag, // stage two offset magnitude
    output logic       [6:0] stage3_gain,    // stage three gain code
    output logic             stage3_ofs_neg, // stage three offset sign
    output logic       [5:0] stage3_ofs_mag  // stage three offset magnitude
);
    import afe_pkg::*;

    // ************************************************************
    // register file
    // ************************************************************
    logic [3:0] enable_word;
    logic [1:0] stage2_gain_r;
    logic [3:0] stage2_offset;
    logic       stage1_gain_r;
    logic [6:0] stage3_gain_r;
    logic [6:0] stage3_offset;
    logic [4:0] input_select;
    logic       reference_select;
    logic       apply;

    wire logic acc      = psel & penable;
    wire logic wr       = acc & pwrite;
    wire logic hit_en   = paddr == `AFE_OFF_STAGE_EN;
    wire logic hit_g2   = paddr == `AFE_OFF_GAIN_OFS2;
    wire logic hit_g3   = paddr == `AFE_OFF_GAIN3;
    wire logic hit_o3   = paddr == `AFE_OFF_OFS3;
    wire logic hit_in   = paddr == `AFE_OFF_INSEL;
    wire logic hit_st   = paddr == `AFE_OFF_STATUS;
    wire logic mapped   = hit_en | hit_g2 | hit_g3 | hit_o3 | hit_in | hit_st;
    wire logic [7:0] insel_byte =
        {2'h0, input_select, reference_select};

    // zero wait states: every access ends in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_word      <= `AFE_RST_STAGE_EN;
            stage2_gain_r    <= 2'h0;
            stage2_offset    <= 4'h0;
            stage1_gain_r    <= 1'b0;
            stage3_gain_r    <= 7'h00;
            stage3_offset    <= 7'h00;
            input_select     <= 5'h00;
            reference_select <= 1'b0;
        end
        else if (wr)
        begin
            if (hit_en)
                enable_word <= pwdata[3:0];
            if (hit_g2)
            begin
                stage2_gain_r <= pwdata[5:4];
                stage2_offset <= pwdata[3:0];
            end
            if (hit_g3)
            begin
                stage1_gain_r <= pwdata[7];
                stage3_gain_r <= pwdata[6:0];
            end
            if (hit_o3)
                stage3_offset <= pwdata[6:0];
            if (hit_in)
            begin
                input_select     <= pwdata[5:1];
                reference_select <= pwdata[0];
            end
        end
    end

    // apply pulses the cycle after a completed write to a mapped address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            apply <= 1'b0;
        else
            apply <= wr & mapped;
    end

    // read mux; status shows the applied stage enables, modulator enable and positive switches
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (hit_en)
            prdata = {28'h0, enable_word};
        else if (hit_g2)
            prdata = {26'h0, stage2_gain_r, stage2_offset};
        else if (hit_g3)
            prdata = {24'h0, stage1_gain_r, stage3_gain_r};
        else if (hit_o3)
            prdata = {25'h0, stage3_offset};
        else if (hit_in)
            prdata = {24'h0, insel_byte};
        else if (hit_st)
            prdata = {20'h0, stage_en, mod_en, pos_sel};
    end

    // ************************************************************
    // decode
    // ************************************************************
    afe_chan_t  pos_next;
    afe_chan_t  neg_next;
    afe_ref_t   ref_next;

    afe_mux_dec u_mux
    (
        .input_select     (input_select),
        .reference_select (reference_select),
        .pos_sel          (pos_next),
        .neg_sel          (neg_next),
        .ref_sel          (ref_next)
    );

    // magnitudes 6 and 7 have no capacitor set; force zero
    wire logic       ofs2_ok   = stage2_offset[2:0] <= `AFE_OFS2_MAX;
    wire logic [2:0] next_mag2 =
        ofs2_ok ? stage2_offset[2:0] : 3'h0;
    // minus zero drives as plus zero, as on stage three
    wire logic       next_neg2 = ofs2_ok & stage2_offset[3]
        & (stage2_offset[2:0] != 3'h0);
    // minus zero drives as plus zero so the sign switch stays idle
    wire logic       next_neg3 =
        stage3_offset[6] & (stage3_offset[5:0] != 6'h00);

    // ************************************************************
    // registered analog controls
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // reset pattern is the decode of the reset selection word
            pos_sel        <= 8'h02;
            neg_sel        <= 8'h01;
            ref_sel        <= 4'h3;
            mod_en         <= 1'b1;
            stage_en       <= 3'h0;
            stage_bypass   <= 3'h7;
            stage1_gain    <= 1'b0;
            stage2_gain    <= 2'h0;
            stage2_ofs_neg <= 1'b0;
            stage2_ofs_mag <= 3'h0;
            stage3_gain    <= 7'h00;
            stage3_ofs_neg <= 1'b0;
            stage3_ofs_mag <= 6'h00;
        end
        else if (apply)
        begin
            pos_sel        <= pos_next;
            neg_sel        <= neg_next;
            ref_sel        <= ref_next;
            mod_en         <= enable_word[0];
            stage_en       <= enable_word[3:1];
            stage_bypass   <= ~enable_word[3:1];
            stage1_gain    <= stage1_gain_r;
            stage2_gain    <= stage2_gain_r;
            stage2_ofs_neg <= next_neg2;
            stage2_ofs_mag <= next_mag2;
            stage3_gain    <= stage3_gain_r;
            stage3_ofs_neg <= next_neg3;
            stage3_ofs_mag <= stage3_offset[5:0];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    reset_mod_a : assert property (
        @(posedge pclk)
        $rose(presetn) |-> mod_en && stage_en == 3'h0)
        else $error("reset state wrong");
    rst_regs_a : assert property (
        @(posedge pclk)
        $rose(presetn) |-> enable_word == `AFE_RST_STAGE_EN
            && input_select == 5'h00 && stage3_offset == 7'h00)
        else $error("register reset wrong");
    onehot_sel_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        $onehot(pos_sel) && $onehot(neg_sel))
        else $error("mux select not one-hot");
    diff_pair_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply && !input_select[4] && !input_select[3]
        |=> pos_sel[{$past(input_select[1:0]), 1'b1}]
            && neg_sel[{$past(input_select[1:0]), 1'b0}])
        else $error("differential pair wrong");
    common_ref_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply && input_select[4] && !input_select[3]
        |=> neg_sel == 8'h01)
        else $error("common reference not on input 0");
    common_sig_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply && input_select[4] && !input_select[3]
        |=> pos_sel[$past(input_select[2:0])])
        else $error("common mode signal input wrong");
    swap_pair_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply && !input_select[4] && input_select[3]
        |=> neg_sel[{$past(input_select[1:0]), 1'b1}])
        else $error("swap not applied");
    swap_common_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply && input_select[4] && input_select[3]
        |=> pos_sel == 8'h01
            && neg_sel[$past(input_select[2:0])])
        else $error("common mode swap not applied");
    ref_pair_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply |=> ref_sel == ($past(reference_select) ? 4'hC : 4'h3))
        else $error("reference pair wrong");
    bypass_inv_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        stage_bypass == ~stage_en)
        else $error("bypass not inverse of enable");
    gain_follow_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply |=> stage1_gain == $past(stage1_gain_r)
            && stage2_gain == $past(stage2_gain_r)
            && stage3_gain == $past(stage3_gain_r))
        else $error("gain code not applied");
    ofs2_legal_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        stage2_ofs_mag <= 3'h5 && !(stage2_ofs_neg && stage2_ofs_mag == 3'h0))
        else $error("illegal stage two offset");
    ofs2_follow_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply && stage2_offset[2:0] <= `AFE_OFS2_MAX
        |=> stage2_ofs_mag == $past(stage2_offset[2:0]))
        else $error("stage two offset not applied");
    ofs2_clip_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply && stage2_offset[2:0] > `AFE_OFS2_MAX
        |=> stage2_ofs_mag == 3'h0 && !stage2_ofs_neg)
        else $error("undefined offset magnitude driven");
    ofs3_zero_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        stage3_ofs_mag == 6'h00 |-> !stage3_ofs_neg)
        else $error("minus zero on stage three");
    ofs3_follow_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply |=> stage3_ofs_mag == $past(stage3_offset[5:0]))
        else $error("stage three offset not applied");
    hold_out_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        !apply |=> $stable(pos_sel) && $stable(stage3_gain))
        else $error("control changed without write");
    apply_src_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply |-> $past(psel && penable && pwrite))
        else $error("controls applied without a write");
    unmapped_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && !mapped |=> !apply)
        else $error("unmapped write applied controls");
    en_follow_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        apply |=> mod_en == $past(enable_word[0])
            && stage_en == $past(enable_word[3:1]))
        else $error("enable not applied");
endmodule : afe_frontend
`default_nettype wire

// *** verification/afe_switch_model.sv ***
// behavioural model of the analog switch network behind the decoder
`timescale 1ns/1ps
`default_nettype none
module afe_switch_model
    import afe_pkg::*;
(
    input  wire afe_pkg::afe_chan_t pos_sel, // positive input switches
    input  wire afe_pkg::afe_chan_t neg_sel, // negative input switches
    input  wire afe_pkg::afe_ref_t  ref_sel, // reference pin switches
    output logic                    ref_hi,  // pins 3/2 carry reference
    output logic                    fault    // illegal switch pattern
);
    // two closed switches on one side would short two sensor inputs
    assign ref_hi = (ref_sel == 4'hC);
    assign fault  = !$onehot(pos_sel) || !$onehot(neg_sel)
                    || !(ref_sel inside {4'h3, 4'hC});
endmodule : afe_switch_model
`default_nettype wire

// *** verification/adc_frontend_mux_gain_decode_tb.sv ***
// self-checking bench for the front-end control decoder
`timescale 1ns/1ps
`default_nettype none
`include "afe_cfg.svh"
module adc_frontend_mux_gain_decode_tb import afe_pkg::*;;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, mod_en, stage1_gain, ref_hi, fault;
    afe_chan_t   pos_sel, neg_sel;
    afe_ref_t    ref_sel;
    logic [3:1]  stage_en, stage_bypass;
    logic [1:0]  stage2_gain;
    logic [2:0]  stage2_ofs_mag;
    logic [6:0]  stage3_gain;
    logic [5:0]  stage3_ofs_mag;
    logic        stage2_ofs_neg, stage3_ofs_neg;
    int          miscompares = 0;
    int          total_checks = 0;

    afe_frontend afe_frontend_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pos_sel(pos_sel), .neg_sel(neg_sel),
        .ref_sel(ref_sel), .mod_en(mod_en), .stage_en(stage_en),
        .stage_bypass(stage_bypass), .stage1_gain(stage1_gain),
        .stage2_gain(stage2_gain), .stage2_ofs_neg(stage2_ofs_neg),
        .stage2_ofs_mag(stage2_ofs_mag), .stage3_gain(stage3_gain),
        .stage3_ofs_neg(stage3_ofs_neg), .stage3_ofs_mag(stage3_ofs_mag));
    afe_switch_model afe_switch_model_inst (.pos_sel(pos_sel),
        .neg_sel(neg_sel), .ref_sel(ref_sel), .ref_hi(ref_hi),
        .fault(fault));

    always #5 pclk = ~pclk;

    // ********************
    // bus tasks and checks
    // ********************
    task automatic summarize;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // ends 1 ns past the edge after release, when applied controls settle
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            miscompares++;
            $display("[ERR] t=%0t pready=%h exp=%h", $time, pready, 1'b1);
            summarize();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
            #1;
        end
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, err}, 32'h0);
    endtask : rdchk

    // *********
    // scenarios
    // *********
    task automatic t_reset;
        chk({28'h0, stage_en, mod_en}, 32'h1);
        chk({29'h0, stage_bypass}, 32'h7);
        chk(pos_sel, 32'h02);
        chk(neg_sel, 32'h01);
        for (int a = 0; a <= 16; a += 4)
            rdchk(a[11:0], a == 0 ? 32'h1 : 32'h0);
    endtask : t_reset

    task automatic t_mux;
        logic [2:0] p, q;
        for (int i = 0; i < 64; i++)
        begin
            p = i[5] ? i[3:1] : {i[2:1], 1'b1};
            q = i[5] ? 3'h0 : {i[2:1], 1'b0};
            if (i[4])
                {p, q} = {q, p};
            apb(1'b1, `AFE_OFF_INSEL, i);
            chk(pos_sel, 8'(8'h01 << p));
            chk(neg_sel, 8'(8'h01 << q));
            chk({31'h0, ref_hi}, {31'h0, i[0]});
            chk({31'h0, fault}, 32'h0);
            rdchk(`AFE_OFF_INSEL, i);
        end
    endtask : t_mux

    task automatic t_amps;
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, `AFE_OFF_STAGE_EN, 32'hFFFFFFF0 | i);
            chk({stage_en, mod_en}, i);
            chk(stage_bypass, 3'(~i[3:1]));
            rdchk(`AFE_OFF_STAGE_EN, i);
        end
        for (int i = 0; i < 64; i++)
        begin
            apb(1'b1, `AFE_OFF_GAIN_OFS2, i);
            chk(stage2_gain, i[5:4]);
            chk(stage2_ofs_mag, i[2:0] > `AFE_OFS2_MAX ? 0 : i[2:0]);
            chk(stage2_ofs_neg, i[3] && i[2:0] inside {[1:5]});
            rdchk(`AFE_OFF_GAIN_OFS2, i);
        end
        for (int i = 0; i < 128; i++)
        begin
            apb(1'b1, `AFE_OFF_GAIN3, {i[0], i[6:0]});
            apb(1'b1, `AFE_OFF_OFS3, i);
            chk(stage3_gain, i[6:0]);
            chk(stage1_gain, i[0]);
            chk(stage3_ofs_mag, i[5:0]);
            chk(stage3_ofs_neg, i[6] && i[5:0] != 6'h00);
            rdchk(`AFE_OFF_GAIN3, {i[0], i[6:0]});
            rdchk(`AFE_OFF_OFS3, i);
        end
    endtask : t_amps

    // zero data would clear the enables if the unmapped slot aliased them
    task automatic t_err;
        apb(1'b1, 12'h018, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({stage_en, stage3_gain}, 10'h3FF);
        apb(1'b0, 12'h018, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        rdchk(`AFE_OFF_STATUS, 32'hF01);
    endtask : t_err

    // reset again in mid-run: registers and controls must return home
    task automatic t_rerun;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset();
    endtask : t_rerun

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset();
        t_mux();
        t_amps();
        t_err();
        t_rerun();
        summarize();
    end
endmodule : adc_frontend_mux_gain_decode_tb
`default_nettype wire
